// ===== logic/hdx_serial_port.sv
// half-duplex asynchronous serial port with AHB-Lite registers
// assumes timer_edge_input and cts_n already synchronous to clk_sys
`timescale 1ns/10ps
module hdx_serial_port
  import hdx_pkg::*;
#(
  parameter int CLK_HZ   = 10_000_000,
  parameter int BIT_RATE = 9600
)
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        timer_edge_input,
  output logic             serial_out_pin,
  input  wire logic        cts_n,
  output logic             rts_n
);

  localparam int CYC_BIT  = CLK_HZ / BIT_RATE;
  localparam int CYC_SBIT = CYC_BIT + CYC_BIT / 2;
  localparam int SH_BIT   = hdx_shift(CYC_BIT);
  localparam int SH_SBIT  = hdx_shift(CYC_SBIT);
  localparam logic [7:0]  LOAD_BIT  = 8'(256 - (CYC_BIT >> SH_BIT));
  localparam logic [7:0]  LOAD_SBIT = 8'(256 - (CYC_SBIT >> SH_SBIT));
  localparam logic [15:0] MASK_BIT  = 16'((1 << SH_BIT) - 1);
  localparam logic [15:0] MASK_SBIT = 16'((1 << SH_SBIT) - 1);

  if (CYC_BIT < 4 || SH_SBIT > 15)
    $error("bit rate does not fit this clock");

  hdx_state_e  state_q;
  hdx_cfg_s    cfg_q;
  logic [7:0]  tx_hold_q;
  logic [7:0]  rx_hold_q;
  logic [7:0]  rx_data_q;
  logic [9:0]  tx_shift_q;
  logic [3:0]  cnt_q;
  logic        busy_q;
  logic        allow_q;
  logic        rxprg_q;
  logic        pend_q;
  logic        perr_q;
  logic        ferr_q;
  logic        pbit_q;
  logic [7:0]  tmr_q;
  logic [15:0] pre_q;
  logic [15:0] mask_q;
  logic [1:0]  tmode_q;
  logic        rx_prev_q;
  logic [7:0]  addr_q;
  logic        wr_q;
  logic        rd_q;

  // bus
  logic        take;
  logic        wr_stat;
  logic        wr_cfg;
  logic        wr_tx;
  logic        wr_cmd;
  logic [31:0] rd_val;
  // engine
  logic        free;
  logic        send_req;
  logic        recv_req;
  logic        tick;
  logic        fall;
  logic        ovf;
  logic        cts_ok;
  logic        arm_edge;
  logic        go_sbit;
  logic        go_bit;
  logic [7:0]  wl_mask;
  logic        tx_par;
  logic [9:0]  frame;
  logic [3:0]  last;
  logic [3:0]  wl_in;

  assign take    = hsel && htrans[1] && hready;
  assign wr_stat = wr_q && addr_q == A_STATUS;
  assign wr_cfg  = wr_q && addr_q == A_CONFIG;
  assign wr_tx   = wr_q && addr_q == A_TXHOLD;
  assign wr_cmd  = wr_q && addr_q == A_CMD;

  assign free     = !busy_q && !pend_q && state_q == ST_IDLE;
  assign send_req = wr_cmd && hwdata[C_SEND] && free;
  assign recv_req = wr_cmd && hwdata[C_RECV] && !hwdata[C_SEND] && free;

  always_comb
  begin
    if (hwdata[3:0] > WL_MAX)
      wl_in = WL_MAX;
    else if (hwdata[3:0] < WL_MIN)
      wl_in = WL_MIN;
    else
      wl_in = hwdata[3:0];
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (addr_q == A_STATUS)
    begin
      rd_val[S_BUSY]  = busy_q;
      rd_val[S_ALLOW] = allow_q;
      rd_val[S_RXPRG] = rxprg_q;
      rd_val[S_PEND]  = pend_q;
      rd_val[S_PERR]  = perr_q;
      rd_val[S_FERR]  = ferr_q;
      rd_val[S_PBIT]  = pbit_q;
    end
    else if (addr_q == A_CONFIG)
      rd_val[6:0] = cfg_q;
    else if (addr_q == A_TXHOLD)
      rd_val[7:0] = tx_hold_q;
    else if (addr_q == A_RXHOLD)
      rd_val[7:0] = rx_hold_q;
  end

  // reads take one wait state so a write just before is seen
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      addr_q    <= 8'h00;
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      wr_q  <= take && hwrite;
      rd_q  <= take && !hwrite;
      if (take)
        addr_q <= haddr[7:0];
      if (take && !hwrite)
        hreadyout <= 1'b0;
      else
        hreadyout <= 1'b1;
      if (rd_q)
        hrdata <= rd_val;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      cfg_q     <= CFG_RESET;
      tx_hold_q <= 8'h00;
    end
    else
    begin
      if (wr_cfg)
        cfg_q <= '{hs_on: hwdata[6], odd: hwdata[5], par_en: hwdata[4], wlen: wl_in};
      if (wr_tx)
        tx_hold_q <= hwdata[7:0];
    end
  end

  // bit timer: edge counter or prescaled internal counter
  assign tick = tmode_q == T_INT && pre_q == mask_q;
  assign fall = tmode_q == T_EDGE && rx_prev_q && !timer_edge_input;
  assign ovf  = (tick || fall) && tmr_q == 8'hFF;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      tmr_q     <= 8'h00;
      pre_q     <= 16'h0000;
      mask_q    <= 16'h0000;
      tmode_q   <= T_OFF;
      rx_prev_q <= 1'b1;
    end
    else
    begin
      rx_prev_q <= timer_edge_input;
      if (arm_edge)
      begin
        tmr_q   <= EDGE_LOAD;
        tmode_q <= T_EDGE;
      end
      else if (go_sbit)
      begin
        tmr_q   <= LOAD_SBIT;
        mask_q  <= MASK_SBIT;
        pre_q   <= 16'h0000;
        tmode_q <= T_INT;
      end
      else if (go_bit)
      begin
        tmr_q   <= LOAD_BIT;
        mask_q  <= MASK_BIT;
        pre_q   <= 16'h0000;
        tmode_q <= T_INT;
      end
      else if (state_q == ST_IDLE)
        tmode_q <= T_OFF;
      else if (ovf && tmode_q == T_EDGE)
      begin
        tmr_q   <= 8'h00;
        tmode_q <= T_OFF;
      end
      else if (ovf)
      begin
        tmr_q  <= LOAD_BIT;
        mask_q <= MASK_BIT;
        pre_q  <= 16'h0000;
      end
      else if (tick)
      begin
        tmr_q <= tmr_q + 8'h01;
        pre_q <= 16'h0000;
      end
      else if (fall)
        tmr_q <= tmr_q + 8'h01;
      else if (tmode_q == T_INT)
        pre_q <= pre_q + 16'h0001;
    end
  end

  assign cts_ok   = !cfg_q.hs_on || !cts_n;
  assign arm_edge = (state_q == ST_IDLE && recv_req)
                 || (state_q == ST_RXCHK && timer_edge_input);
  assign go_sbit  = state_q == ST_RXCHK && !timer_edge_input;
  assign go_bit   = state_q == ST_TXCTS && allow_q && cts_ok;

  assign wl_mask = 8'((9'h001 << cfg_q.wlen) - 9'h001);
  assign tx_par  = hdx_fold(tx_hold_q & wl_mask) ^ cfg_q.odd;
  assign last    = cfg_q.wlen + {3'h0, cfg_q.par_en};

  // data LSB first, then parity, rest ones for the single stop bit
  always_comb
  begin
    frame = 10'h3FF;
    for (int i = 0; i < 8; i++)
      if (i < int'(cfg_q.wlen))
        frame[i] = tx_hold_q[i];
    if (cfg_q.par_en)
      frame[cfg_q.wlen] = tx_par;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      state_q        <= ST_IDLE;
      tx_shift_q     <= 10'h3FF;
      cnt_q          <= 4'h0;
      serial_out_pin <= 1'b1;
      rx_data_q      <= 8'h00;
      rx_hold_q      <= 8'h00;
      busy_q         <= 1'b0;
      allow_q        <= 1'b0;
      rxprg_q        <= 1'b0;
      pend_q         <= 1'b0;
      perr_q         <= 1'b0;
      ferr_q         <= 1'b0;
      pbit_q         <= 1'b0;
    end
    else
    begin
      if (wr_stat)
        allow_q <= hwdata[S_ALLOW];
      case (state_q)
        ST_IDLE:
        begin
          if (send_req)
          begin
            allow_q    <= 1'b1;
            busy_q     <= 1'b1;
            tx_shift_q <= frame;
            pbit_q     <= tx_par;
            state_q    <= ST_TXCTS;
          end
          else if (recv_req)
          begin
            pend_q  <= 1'b1;
            perr_q  <= 1'b0;
            ferr_q  <= 1'b0;
            state_q <= ST_RXARM;
          end
        end
        ST_TXCTS:
        begin
          if (!allow_q)
          begin
            busy_q  <= 1'b0;
            state_q <= ST_IDLE;
          end
          else if (cts_ok)
          begin
            serial_out_pin <= 1'b0;
            cnt_q          <= 4'h0;
            state_q        <= ST_TX;
          end
        end
        ST_TX:
        begin
          if (!allow_q)
          begin
            serial_out_pin <= 1'b1;
            busy_q         <= 1'b0;
            state_q        <= ST_IDLE;
          end
          else if (ovf && cnt_q == last + 4'h1)
          begin
            busy_q  <= 1'b0;
            state_q <= ST_IDLE;
          end
          else if (ovf)
          begin
            serial_out_pin <= tx_shift_q[0];
            tx_shift_q     <= {1'b1, tx_shift_q[9:1]};
            cnt_q          <= cnt_q + 4'h1;
          end
        end
        ST_RXARM:
        begin
          if (ovf)
            state_q <= ST_RXCHK;
        end
        ST_RXCHK:
        begin
          if (!timer_edge_input)
          begin
            rxprg_q   <= 1'b1;
            rx_data_q <= 8'h00;
            cnt_q     <= 4'h0;
            state_q   <= ST_RXBIT;
          end
          else
            state_q <= ST_RXARM;
        end
        ST_RXBIT:
        begin
          if (ovf)
          begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q < cfg_q.wlen)
              rx_data_q[cnt_q[2:0]] <= timer_edge_input;
            else if (cfg_q.par_en && cnt_q == cfg_q.wlen)
              pbit_q <= timer_edge_input;
            else
            begin
              ferr_q    <= !timer_edge_input;
              perr_q    <= cfg_q.par_en
                        && ((hdx_fold(rx_data_q) ^ cfg_q.odd) != pbit_q);
              rx_hold_q <= rx_data_q;
              pend_q    <= 1'b0;
              rxprg_q   <= 1'b0;
              state_q   <= ST_IDLE;
            end
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // rts low only while waiting for or taking in a character
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      rts_n <= 1'b1;
    else
      rts_n <= !(cfg_q.hs_on && (state_q == ST_RXARM || state_q == ST_RXCHK
                                 || state_q == ST_RXBIT));
  end

endmodule

// ===== logic/hdx_pkg.sv
// constants and types of the half-duplex serial port
// assumes one 10 MHz clock and an AHB-Lite register bus
package hdx_pkg;

  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_CONFIG = 8'h04;
  localparam logic [7:0] A_TXHOLD = 8'h08;
  localparam logic [7:0] A_RXHOLD = 8'h0C;
  localparam logic [7:0] A_CMD    = 8'h10;

  localparam int S_BUSY  = 0;
  localparam int S_ALLOW = 1;
  localparam int S_RXPRG = 2;
  localparam int S_PEND  = 3;
  localparam int S_PERR  = 4;
  localparam int S_FERR  = 5;
  localparam int S_PBIT  = 7;

  localparam int C_SEND = 0;
  localparam int C_RECV = 1;

  localparam logic [3:0] WL_MAX = 4'h8;
  localparam logic [3:0] WL_MIN = 4'h1;

  localparam logic [1:0] T_OFF  = 2'h0;
  localparam logic [1:0] T_EDGE = 2'h1;
  localparam logic [1:0] T_INT  = 2'h2;

  localparam logic [7:0] EDGE_LOAD = 8'hFF;

  // config register layout, from bit 6 down to bit 0
  typedef struct packed {
    logic       hs_on;
    logic       odd;
    logic       par_en;
    logic [3:0] wlen;
  } hdx_cfg_s;

  localparam hdx_cfg_s CFG_RESET = '{hs_on: 1'b0, odd: 1'b0, par_en: 1'b0, wlen: 4'h8};

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_TXCTS = 6'h02,
    ST_TX    = 6'h04,
    ST_RXARM = 6'h08,
    ST_RXCHK = 6'h10,
    ST_RXBIT = 6'h20
  } hdx_state_e;

  // smallest prescale shift that fits a period in the 8-bit timer
  function automatic int hdx_shift(input int cyc);
    int s;
    s = 0;
    for (int i = 0; i < 16; i++)
      if ((cyc >> s) > 256)
        s = s + 1;
    return s;
  endfunction

  function automatic logic hdx_fold(input logic [7:0] d);
    logic [3:0] n;
    logic [1:0] p;
    n = d[7:4] ^ d[3:0];
    p = n[3:2] ^ n[1:0];
    return p[1] ^ p[0];
  endfunction

endpackage

// ===== tb/hdx_serial_port_asserts.sv
// port checker for the half-duplex serial port
// assumes one clock domain; bound to the port block by the bench
`timescale 1ns/10ps
module hdx_serial_port_asserts
#(
  parameter int CLK_HZ   = 10_000_000,
  parameter int BIT_RATE = 9600
)
(
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        timer_edge_input,
  input wire logic        serial_out_pin,
  input wire logic        cts_n,
  input wire logic        rts_n
);
  localparam int CYC = CLK_HZ / BIT_RATE;
  int run_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // edges the line has held its level; saturates so idle never wraps
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      run_q <= 16 * CYC;
    else if ($changed(serial_out_pin))
      run_q <= 1;
    else if (run_q < 16 * CYC)
      run_q <= run_q + 1;
  end
  sequence s_rd_req; hsel && htrans[1] && hready && !hwrite; endsequence
  sequence s_wr_req; hsel && htrans[1] && hready && hwrite; endsequence
  sequence s_rd_ans; !hreadyout ##1 hreadyout; endsequence
  property p_rd_wait; s_rd_req |=> s_rd_ans; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait not one cycle");
  property p_wr_nowait; s_wr_req |=> hreadyout; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_okay; hresp == 1'h0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_rd_hold; $changed(hrdata) |-> !$past(hreadyout); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_idle; $rose(resetn) |-> serial_out_pin && rts_n; endproperty
  a_idle: assert property (p_idle) else $error("lines not idle");
  property p_bit_len; $changed(serial_out_pin) |-> run_q >= CYC; endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit too short");
  // the edge that sees a fresh low still samples the old run length
  property p_low_max;
    !serial_out_pin && !$changed(serial_out_pin) |-> run_q < 10 * CYC;
  endproperty
  a_low_max: assert property (p_low_max) else $error("no stop bit");
  property p_hdx; !rts_n |-> serial_out_pin; endproperty
  a_hdx: assert property (p_hdx) else $error("sending in rx mode");
endmodule

// ===== tb/hdx_host_model.sv
// far-side serial host: drives the receive line, captures sent frames
// assumes the device clock and CYC clocks per bit
`timescale 1ns/10ps
module hdx_host_model
#(
  parameter int CYC = 10
)
(
  input  wire logic clk,
  input  wire logic tx_line,
  output logic      rx_line
);
  initial rx_line = 1'h1;
  // lsb first, one bit time each, back to mark after the stop
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      rx_line <= f[i];
      repeat (CYC) @(posedge clk);
    end
    rx_line <= 1'h1;
  endtask
  // dip shorter than the start re-check
  task automatic glitch();
    rx_line <= 1'h0;
    @(posedge clk);
    rx_line <= 1'h1;
  endtask
  task automatic capture(input int n, output logic [10:0] f, output logic ok);
    int k;
    f = 11'h7FF;
    k = 0;
    @(posedge clk);
    while (tx_line !== 1'h0 && k < 2000)
    begin
      k++;
      @(posedge clk);
    end
    ok = (k < 2000);
    // centre of each bit
    repeat (CYC / 2) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      f[i] = tx_line;
      repeat (CYC) @(posedge clk);
    end
  endtask
endmodule

// ===== tb/hdx_serial_port_tb.sv
// bench for the half-duplex serial port: AHB-Lite master plus host model
// assumes a 10 bit-clock period through a raised bit rate
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("MISMATCH %s exp %0h got %0h", nm, (e), (g)); \
    end \
  end
module hdx_serial_port_tb
  import hdx_pkg::*;
;
  localparam int RATE = 1_000_000;
  localparam int CYC  = 10_000_000 / RATE;
  logic        clk_sys, resetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        timer_edge_input, serial_out_pin, cts_n, rts_n;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int          n_fail, samples_checked;
  assign hready = hreadyout;
  hdx_serial_port #(.BIT_RATE(RATE)) hdx_serial_port_inst (
    .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_edge_input(timer_edge_input),
    .serial_out_pin(serial_out_pin), .cts_n(cts_n), .rts_n(rts_n));
  hdx_host_model #(.CYC(CYC)) hdx_host_model_inst (
    .clk(clk_sys), .tx_line(serial_out_pin), .rx_line(timer_edge_input));
  task automatic results();
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'h1)
    begin
      k++;
      if (k > 20)
      begin
        n_fail++;
        results();
      end
      @(posedge clk_sys);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'h1, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(a, 1'h0, 32'h00000000, d);
  endtask
  // poll until neither busy nor pending
  task automatic wait_free();
    logic [31:0] s;
    int k;
    k = 0;
    do
    begin
      rd(A_STATUS, s);
      k++;
    end
    while ((s[3] | s[0]) !== 1'h0 && k < 400);
    if (k >= 400)
    begin
      n_fail++;
      results();
    end
  endtask
  function automatic logic [10:0] frame(input logic [7:0] d, input logic [6:0] c);
    logic [10:0] f;
    int w;
    w = c[3:0];
    f = 11'h7FE;
    for (int i = 0; i < w; i++)
      f[i+1] = d[i];
    if (c[4])
      f[w+1] = ^(d & (8'hFF >> (8 - w))) ^ c[5];
    return f;
  endfunction
  task automatic t_regs();
    logic [31:0] s;
    logic [7:0]  a [5] = '{A_STATUS, A_CONFIG, A_TXHOLD, A_RXHOLD, 8'h14};
    wr(A_RXHOLD, 32'h000000FF);
    wr(8'h14, 32'h000000FF);
    for (int i = 0; i < 5; i++)
    begin
      rd(a[i], s);
      `CHK("reset value", (i == 1) ? 32'h00000008 : 32'h00000000, s);
    end
    wr(A_CONFIG, 32'h00000000);
    rd(A_CONFIG, s);
    `CHK("wlen clamp low", 32'h00000001, s);
    wr(A_CONFIG, 32'h0000000F);
    rd(A_CONFIG, s);
    `CHK("wlen clamp high", 32'h00000008, s);
  endtask
  task automatic t_tx(input logic [7:0] d, input logic [6:0] c);
    logic [31:0] s;
    logic [10:0] got;
    logic        ok;
    cts_n <= 1'h1;
    wr(A_CONFIG, {25'h0000000, c});
    wr(A_TXHOLD, {24'h000000, d});
    fork
      hdx_host_model_inst.capture(c[3:0] + 2 + c[4], got, ok);
      begin
        wr(A_CMD, 32'h00000001);
        rd(A_STATUS, s);
        `CHK("busy allow", 2'h3, s[1:0]);
        wr(A_CMD, 32'h00000002);
        rd(A_STATUS, s);
        `CHK("rx refused", 1'h0, s[3]);
        if (c[6])
        begin
          repeat (3 * CYC) @(posedge clk_sys);
          `CHK("cts hold", 1'h1, serial_out_pin);
          cts_n <= 1'h0;
        end
      end
    join
    `CHK("start seen", 1'h1, ok);
    if (ok !== 1'h1)
      results();
    `CHK("tx frame", frame(d, c), got);
    wait_free();
    rd(A_STATUS, s);
    `CHK("ninth bit", (^(d & (8'hFF >> (8 - c[3:0]))) ^ c[5]), s[7]);
  endtask
  // bad: bit0 flips parity, bit1 low stop, bit2 glitch first
  task automatic t_rx(input logic [7:0] d, input logic [6:0] c, input logic [2:0] bad);
    logic [31:0] s;
    logic [10:0] f;
    int          n;
    n = c[3:0] + 2 + c[4];
    f = frame(d, c);
    if (bad[0])
      f[c[3:0]+1] = ~f[c[3:0]+1];
    if (bad[1])
      f[n-1] = 1'h0;
    wr(A_CONFIG, {25'h0000000, c});
    wr(A_CMD, 32'h00000002);
    rd(A_STATUS, s);
    `CHK("rx armed", 4'h2, s[5:2]);
    `CHK("rts in rx", ~c[6], rts_n);
    if (bad[2])
    begin
      hdx_host_model_inst.glitch();
      repeat (CYC) @(posedge clk_sys);
      rd(A_STATUS, s);
      `CHK("glitch", 4'h2, s[5:2]);
    end
    hdx_host_model_inst.send(f, n);
    wait_free();
    rd(A_RXHOLD, s);
    `CHK("rx data", {24'h000000, d & (8'hFF >> (8 - c[3:0]))}, s);
    rd(A_STATUS, s);
    `CHK("rx errors", bad[1:0], s[5:4]);
    `CHK("rts after", 1'h1, rts_n);
  endtask
  task automatic t_abort();
    logic [31:0] s;
    wr(A_CONFIG, 32'h00000008);
    // all-zero data keeps the line low, so the abort must visibly raise it
    wr(A_TXHOLD, 32'h00000000);
    wr(A_CMD, 32'h00000001);
    repeat (3 * CYC) @(posedge clk_sys);
    wr(A_STATUS, 32'h00000000);
    rd(A_STATUS, s);
    `CHK("abort", 2'h0, s[1:0]);
    `CHK("abort line", 1'h1, serial_out_pin);
  endtask
  initial
  begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    n_fail = 0;
    samples_checked = 0;
    resetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    cts_n = 1'h1;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'h1;
    @(posedge clk_sys);
    t_regs();
    t_tx(8'hA5, 7'h08);
    t_tx(8'h5B, 7'h17);
    t_tx(8'hC3, 7'h38);
    t_tx(8'h01, 7'h01);
    t_tx(8'h3C, 7'h58);
    t_rx(8'h5A, 7'h08, 3'h0);
    t_rx(8'h96, 7'h18, 3'h1);
    t_rx(8'h2D, 7'h37, 3'h0);
    t_rx(8'h33, 7'h48, 3'h6);
    t_abort();
    results();
  end
endmodule
bind hdx_serial_port hdx_serial_port_asserts #(.CLK_HZ(CLK_HZ), .BIT_RATE(BIT_RATE))
  hdx_serial_port_asserts_inst (
  .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .timer_edge_input(timer_edge_input),
  .serial_out_pin(serial_out_pin), .cts_n(cts_n), .rts_n(rts_n));
